// >>> src/ees_pkg.sv
/*
  Constants and types for the energy event status flag bank.
  Assumes a 25 MHz system clock and an AXI4-Lite register master.
*/
package ees_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_SIGN = 8'h04;
  localparam logic [7:0] ADDR_PULSE_CFG = 8'h08;
  localparam logic [7:0] ADDR_HARM_CFG = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // Status bit positions
  localparam int BIT_SUM1_FLIP = 9;
  localparam int BIT_FVAR_A_FLIP = 10;
  localparam int BIT_FVAR_B_FLIP = 11;
  localparam int BIT_FVAR_C_FLIP = 12;
  localparam int BIT_SUM2_FLIP = 13;
  localparam int BIT_PULSE_ONE = 14;
  localparam int BIT_PULSE_TWO = 15;
  localparam int BIT_PULSE_THREE = 16;
  localparam int BIT_DSP_DONE = 17;
  localparam int BIT_SUM3_FLIP = 18;
  localparam int BIT_HARM_READY = 19;
  localparam logic [31:0] STATUS_IMPL_MASK = 32'h000F_FE00;

  // Sign register bit positions
  localparam int BIT_PATH1_SIGN = 3;
  localparam int BIT_FVAR_A_SIGN = 4;
  localparam int BIT_FVAR_B_SIGN = 5;
  localparam int BIT_FVAR_C_SIGN = 6;
  localparam int BIT_PATH2_SIGN = 7;
  localparam int BIT_PATH3_SIGN = 8;

  // Harmonic config
  localparam int BIT_HARM_READY_TIMING = 1;
  localparam logic [31:0] HARM_CFG_IMPL_MASK = 32'h0000_0002;

  // Reset values
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] PULSE_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] HARM_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] IRQ_MASK_RESET = 32'h0000_0000;

  // Pulse sources selectable by a 3-bit field
  localparam int SEL_W = 3;
  localparam int SRC_NUM = 8;
  localparam int PATH_NUM = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned HARM_SETTLE_MS = 750;
  localparam int unsigned HARM_SETTLE_CYC = HARM_SETTLE_MS * (CLK_HZ / 1000);

  // Pulse output configuration word, bit 0 at the bottom
  typedef struct packed {
    logic [19:0] rsvd;
    logic pulse_three_disable;
    logic pulse_two_disable;
    logic pulse_one_disable;
    logic [2:0] pulse_three_source;
    logic [2:0] pulse_two_source;
    logic [2:0] pulse_one_source;
  } ees_pulse_cfg_type;

  localparam logic [31:0] PULSE_CFG_IMPL_MASK = 32'h0000_0FFF;

  function automatic logic [31:0] strb_bits(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : strb_bits

endpackage : ees_pkg

// >>> src/ees_status_bank.sv
/*
  Event status flag bank with sign register, pulse output routing,
  harmonic ready timing and an AXI4-Lite slave.
  Assumes all inputs synchronous to CLK; event strobes are one-cycle pulses.
*/
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Path one sum sign flip sets bit 9
// - Path two sum sign flip sets bit 13
// - Path three sum sign flip sets bit 18
// - Phase A reactive sign flip sets bit 10
// - Phase B reactive sign flip sets bit 11
// - Phase C reactive sign flip sets bit 12
// - Pulse one falling edge sets bit 14
// - Pulse two falling edge sets bit 15
// - Pulse three falling edge sets bit 16
// - Pulse flags set even when pin disabled
// - Three-bit fields select each pulse source
// - Processing cycle completion sets bit 17
// - Timing bit zero: every harmonic update flags
// - Timing bit one: flag after 750 ms
// - Bits above 19 read zero
module ees_status_bank #(
  parameter int unsigned HARM_SETTLE_CYCLES = ees_pkg::HARM_SETTLE_CYC
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [7:0] PULSE_CAND_N,
  input wire logic [7:0] SUM_SIGN_CAND,
  input wire logic [2:0] FUND_REACTIVE_SIGN,
  input wire logic DSP_CYCLE_DONE,
  input wire logic HARM_UPDATE,
  input wire logic HARM_SETUP,
  output logic [2:0] PULSE_OUT_N,
  output logic IRQ
);

  // Software visible registers
  logic [31:0] status_reg;
  logic [31:0] status_next;
  ees_pkg::ees_pulse_cfg_type pulse_cfg_reg;
  logic [31:0] harm_cfg_reg;
  logic [31:0] irq_mask_reg;
  logic [2:0] path_sign_reg;
  logic [2:0] fvar_sign_reg;
  logic [31:0] sign_word;

  // AXI state
  logic aw_hold_reg;
  logic [7:0] aw_addr_reg;
  logic w_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Pulse paths
  logic [ees_pkg::SEL_W-1:0] path_sel [ees_pkg::PATH_NUM];
  logic [2:0] path_disable;
  logic [2:0] path_pulse_n;
  logic [2:0] path_sum_sign;
  logic [2:0] pulse_prev_reg;
  logic [2:0] pulse_fall;
  logic [2:0] path_sign_flip;
  logic [2:0] fvar_sign_flip;

  // Harmonic settle timer
  logic [31:0] harm_cnt_reg;
  logic harm_run_reg;
  logic harm_settled_reg;
  logic harm_ready_set;

  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic do_write;
  logic wr_hit;
  logic [31:0] wr_mask;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] wr_strb_mask;
  logic [31:0] rd_word;
  logic rd_known;
  logic wr_known;

  assign aw_fire = S_AXI_AWVALID && awready_reg;
  assign w_fire = S_AXI_WVALID && wready_reg;
  assign ar_fire = S_AXI_ARVALID && arready_reg;
  assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_strb_mask = ees_pkg::strb_bits(w_strb_reg);
  assign wr_mask = wr_strb_mask & w_data_reg;

  // Word decode shared by both channels; address bits 1:0 ignored
  function automatic logic addr_known(input logic [7:0] addr);
    logic [7:0] word_addr;
    word_addr = {addr[7:2], 2'h0};
    return (word_addr == ees_pkg::ADDR_STATUS) || (word_addr == ees_pkg::ADDR_SIGN) ||
           (word_addr == ees_pkg::ADDR_PULSE_CFG) || (word_addr == ees_pkg::ADDR_HARM_CFG) ||
           (word_addr == ees_pkg::ADDR_IRQ_MASK);
  endfunction : addr_known

  assign rd_known = addr_known(S_AXI_ARADDR);
  assign wr_known = addr_known(aw_addr_reg);

  assign path_sel[0] = pulse_cfg_reg.pulse_one_source;
  assign path_sel[1] = pulse_cfg_reg.pulse_two_source;
  assign path_sel[2] = pulse_cfg_reg.pulse_three_source;
  assign path_disable = {pulse_cfg_reg.pulse_three_disable, pulse_cfg_reg.pulse_two_disable,
                         pulse_cfg_reg.pulse_one_disable};

  // Per-path pulse routing, edge detection and sum sign tracking
  // A source change can look like an edge or a flip; not suppressed
  for (genvar i = 0; i < ees_pkg::PATH_NUM; i++) begin : g_path
    assign path_pulse_n[i] = PULSE_CAND_N[path_sel[i]];
    assign path_sum_sign[i] = SUM_SIGN_CAND[path_sel[i]];
    assign pulse_fall[i] = pulse_prev_reg[i] && !path_pulse_n[i];
    assign path_sign_flip[i] = DSP_CYCLE_DONE && (path_sum_sign[i] != path_sign_reg[i]);
    assign fvar_sign_flip[i] = DSP_CYCLE_DONE && (FUND_REACTIVE_SIGN[i] != fvar_sign_reg[i]);

    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        pulse_prev_reg[i] <= 1'b1;
        PULSE_OUT_N[i] <= 1'b1;
      end else begin
        pulse_prev_reg[i] <= path_pulse_n[i];
        // Disabled pin idles high; the flag path above ignores the disable
        PULSE_OUT_N[i] <= path_disable[i] ? 1'b1 : path_pulse_n[i];
      end
    end

    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        path_sign_reg[i] <= 1'b0;
        fvar_sign_reg[i] <= 1'b0;
      end else if (DSP_CYCLE_DONE) begin
        path_sign_reg[i] <= path_sum_sign[i];
        fvar_sign_reg[i] <= FUND_REACTIVE_SIGN[i];
      end
    end
  end : g_path

  // Harmonic settle timer, restarted by each setup
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      harm_cnt_reg <= 32'h0000_0000;
      harm_run_reg <= 1'b0;
      harm_settled_reg <= 1'b0;
    end else if (HARM_SETUP) begin
      harm_cnt_reg <= 32'h0000_0000;
      harm_run_reg <= 1'b1;
      harm_settled_reg <= 1'b0;
    end else if (harm_run_reg) begin
      if (harm_cnt_reg == 32'(HARM_SETTLE_CYCLES - 1)) begin
        harm_run_reg <= 1'b0;
        harm_settled_reg <= 1'b1;
      end else begin
        harm_cnt_reg <= harm_cnt_reg + 32'h0000_0001;
      end
    end
  end

  assign harm_ready_set = HARM_UPDATE &&
    (!harm_cfg_reg[ees_pkg::BIT_HARM_READY_TIMING] || harm_settled_reg);

  // Event set vector
  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[ees_pkg::BIT_SUM1_FLIP] = path_sign_flip[0];
    set_vec[ees_pkg::BIT_SUM2_FLIP] = path_sign_flip[1];
    set_vec[ees_pkg::BIT_SUM3_FLIP] = path_sign_flip[2];
    set_vec[ees_pkg::BIT_FVAR_A_FLIP] = fvar_sign_flip[0];
    set_vec[ees_pkg::BIT_FVAR_B_FLIP] = fvar_sign_flip[1];
    set_vec[ees_pkg::BIT_FVAR_C_FLIP] = fvar_sign_flip[2];
    set_vec[ees_pkg::BIT_PULSE_ONE] = pulse_fall[0];
    set_vec[ees_pkg::BIT_PULSE_TWO] = pulse_fall[1];
    set_vec[ees_pkg::BIT_PULSE_THREE] = pulse_fall[2];
    set_vec[ees_pkg::BIT_DSP_DONE] = DSP_CYCLE_DONE;
    set_vec[ees_pkg::BIT_HARM_READY] = harm_ready_set;
  end

  assign wr_hit = do_write && (aw_addr_reg == ees_pkg::ADDR_STATUS);
  assign clr_vec = wr_hit ? wr_mask : 32'h0000_0000;
  // Set wins over a clear in the same cycle
  assign status_next = ((status_reg & ~clr_vec) | set_vec) & ees_pkg::STATUS_IMPL_MASK;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      status_reg <= ees_pkg::STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // Sign register view
  always_comb begin
    sign_word = 32'h0000_0000;
    sign_word[ees_pkg::BIT_PATH1_SIGN] = path_sign_reg[0];
    sign_word[ees_pkg::BIT_FVAR_A_SIGN] = fvar_sign_reg[0];
    sign_word[ees_pkg::BIT_FVAR_B_SIGN] = fvar_sign_reg[1];
    sign_word[ees_pkg::BIT_FVAR_C_SIGN] = fvar_sign_reg[2];
    sign_word[ees_pkg::BIT_PATH2_SIGN] = path_sign_reg[1];
    sign_word[ees_pkg::BIT_PATH3_SIGN] = path_sign_reg[2];
  end

  // Read data for the address on the read channel
  always_comb begin
    unique case ({S_AXI_ARADDR[7:2], 2'h0})
      ees_pkg::ADDR_STATUS: rd_word = status_reg;
      ees_pkg::ADDR_SIGN: rd_word = sign_word;
      ees_pkg::ADDR_PULSE_CFG: rd_word = pulse_cfg_reg;
      ees_pkg::ADDR_HARM_CFG: rd_word = harm_cfg_reg;
      ees_pkg::ADDR_IRQ_MASK: rd_word = irq_mask_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read/write configuration registers with byte strobes
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pulse_cfg_reg <= ees_pkg::PULSE_CFG_RESET;
      harm_cfg_reg <= ees_pkg::HARM_CFG_RESET;
      irq_mask_reg <= ees_pkg::IRQ_MASK_RESET;
    end else if (do_write) begin
      unique case (aw_addr_reg)
        ees_pkg::ADDR_PULSE_CFG: begin
          pulse_cfg_reg <= ((pulse_cfg_reg & ~ees_pkg::strb_bits(w_strb_reg)) |
                            (w_data_reg & ees_pkg::strb_bits(w_strb_reg)))
                           & ees_pkg::PULSE_CFG_IMPL_MASK;
        end
        ees_pkg::ADDR_HARM_CFG: begin
          harm_cfg_reg <= ((harm_cfg_reg & ~ees_pkg::strb_bits(w_strb_reg)) |
                           (w_data_reg & ees_pkg::strb_bits(w_strb_reg)))
                          & ees_pkg::HARM_CFG_IMPL_MASK;
        end
        ees_pkg::ADDR_IRQ_MASK: begin
          irq_mask_reg <= ((irq_mask_reg & ~ees_pkg::strb_bits(w_strb_reg)) |
                           (w_data_reg & ees_pkg::strb_bits(w_strb_reg)))
                          & ees_pkg::STATUS_IMPL_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // Level interrupt from unmasked sticky flags
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(status_reg & irq_mask_reg);
    end
  end

  // Write address and data capture, either order
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      awready_reg <= 1'b0;
    end else if (aw_fire) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= {S_AXI_AWADDR[7:2], 2'h0};
      awready_reg <= 1'b0;
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end else if (!aw_hold_reg && !bvalid_reg) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      wready_reg <= 1'b0;
    end else if (w_fire) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= S_AXI_WDATA;
      w_strb_reg <= S_AXI_WSTRB;
      wready_reg <= 1'b0;
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end else if (!w_hold_reg && !bvalid_reg) begin
      wready_reg <= 1'b1;
    end
  end

  // Write response
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= ees_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      // Unmapped writes change nothing but are refused
      bresp_reg <= wr_known ? ees_pkg::RESP_OKAY : ees_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY && bvalid_reg) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read address acceptance, closed while data is pending
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      arready_reg <= 1'b0;
    end else if (ar_fire) begin
      arready_reg <= 1'b0;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  // Read data valid until the master takes it
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rvalid_reg <= 1'b0;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Read data and response, captured as the address is taken
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= ees_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rdata_reg <= rd_word;
      rresp_reg <= rd_known ? ees_pkg::RESP_OKAY : ees_pkg::RESP_SLVERR;
    end
  end

  assign S_AXI_AWREADY = awready_reg;
  assign S_AXI_WREADY = wready_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

endmodule : ees_status_bank

`default_nettype wire

// >>> bench/ees_status_bank_sva.sv
/* Port checker for the event status flag bank.
   Assumes it is bound to ees_status_bank and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module ees_status_bank_sva (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic [7:0] PULSE_CAND_N,
  input wire logic [2:0] PULSE_OUT_N,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_reset_idle: assert property ($rose(RST_N) |->
    !S_AXI_BVALID && !S_AXI_RVALID && !IRQ && PULSE_OUT_N == 3'h7)
    else $error("outputs not idle after reset");
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
    S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
    else $error("write response missing");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |-> ##[1:2] S_AXI_RVALID)
    else $error("read response missing");
  a_read_unmapped: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h13
    |-> ##[1:2] (S_AXI_RVALID && S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0))
    else $error("unmapped read not refused");
  a_write_refuse: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted while response pending");
  a_read_refuse: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read accepted while data pending");
  a_upper_zero: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:20] == 12'h0)
    else $error("upper read bits not zero");
  a_pulse_idle: assert property (PULSE_CAND_N == 8'hFF |=> PULSE_OUT_N == 3'h7)
    else $error("pulse pin low without source pulse");
  c_write: cover property (S_AXI_AWVALID && S_AXI_AWREADY);
  c_read_err: cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
  c_irq: cover property ($rose(IRQ));
  c_pulse: cover property ($fell(PULSE_OUT_N[0]));
endmodule : ees_status_bank_sva

bind ees_status_bank ees_status_bank_sva i_sva (.CLK, .RST_N, .S_AXI_AWVALID,
  .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARADDR,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
  .PULSE_CAND_N, .PULSE_OUT_N, .IRQ);
`default_nettype wire

// >>> bench/testbench.sv
/* Self-checking bench for the event status flag bank.
   Assumes a 25 MHz clock and a short harmonic settle count. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int SETTLE = 20;
  logic clk = 1'h0, rst_n = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, cand_n = 8'hFF, sum_sign = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic dsp = 1'h0, harm_upd = 1'h0, harm_setup = 1'h0;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] fvar = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] pout_n;
  int failures = 0, samples_checked = 0, cycles = 0;

  ees_status_bank #(.HARM_SETTLE_CYCLES(SETTLE)) i_dut (
    .CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PULSE_CAND_N(cand_n), .SUM_SIGN_CAND(sum_sign), .FUND_REACTIVE_SIGN(fvar),
    .DSP_CYCLE_DONE(dsp), .HARM_UPDATE(harm_upd), .HARM_SETUP(harm_setup),
    .PULSE_OUT_N(pout_n), .IRQ(irq)
  );

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw;
    pa = 1'h1;
    pw = 1'h1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awready) begin
        pa = 1'h0;
        awvalid <= 1'h0;
      end
      if (pw && wready) begin
        pw = 1'h0;
        wvalid <= 1'h0;
      end
    end
    bready <= 1'h1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'h0;
    check("bresp", {30'h0, bresp}, {30'h0, er});
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    rready <= 1'h1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'h0;
    check("rdata", rdata, e);
    check("rresp", {30'h0, rresp}, {30'h0, er});
    @(posedge clk);
  endtask : rd

  // One-cycle strobe: 0 processing done, 1 harmonic update, 2 harmonic setup
  task automatic strobe(input int k);
    case (k)
      0: dsp <= 1'h1;
      1: harm_upd <= 1'h1;
      default: harm_setup <= 1'h1;
    endcase
    @(posedge clk);
    {dsp, harm_upd, harm_setup} <= 3'h0;
    @(posedge clk);
  endtask : strobe

  task automatic t_regs();
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    wr(8'h04, 32'hFFFF_FFFF, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    wr(8'h08, 32'hFFFF_FFFF, 2'h0);
    rd(8'h08, 32'h0000_0FFF, 2'h0);
    wr(8'h0C, 32'hFFFF_FFFF, 2'h0);
    rd(8'h0C, 32'h0000_0002, 2'h0);
    wr(8'h10, 32'hFFFF_FFFF, 2'h0);
    rd(8'h10, 32'h000F_FE00, 2'h0);
    wr(8'h08, 32'h0, 2'h0);
    wr(8'h0C, 32'h0, 2'h0);
    wr(8'h10, 32'h0, 2'h0);
    wstrb <= 4'h2;
    wr(8'h10, 32'hFFFF_FFFF, 2'h0);
    wstrb <= 4'hF;
    rd(8'h10, 32'h0000_FE00, 2'h0);
    wr(8'h10, 32'h0, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h40, 32'hFFFF_FFFF, 2'h2);
  endtask : t_regs

  task automatic t_signs();
    wr(8'h08, 32'h0000_00D1, 2'h0);
    sum_sign <= 8'h0F;
    fvar <= 3'h7;
    strobe(0);
    rd(8'h00, 32'h0006_3E00, 2'h0);
    rd(8'h04, 32'h0000_01F8, 2'h0);
    wr(8'h00, 32'h0, 2'h0);
    rd(8'h00, 32'h0006_3E00, 2'h0);
    wr(8'h00, 32'h0000_0400, 2'h0);
    rd(8'h00, 32'h0006_3A00, 2'h0);
    wr(8'h00, 32'hFFFF_FFFF, 2'h0);
    fvar <= 3'h5;
    strobe(0);
    rd(8'h00, 32'h0002_0800, 2'h0);
    rd(8'h04, 32'h0000_01D8, 2'h0);
    wr(8'h00, 32'hFFFF_FFFF, 2'h0);
  endtask : t_signs

  task automatic t_pulses();
    wr(8'h08, 32'h0000_0ED1, 2'h0);
    cand_n <= 8'hF1;
    repeat (3) @(posedge clk);
    check("pins disabled", {29'h0, pout_n}, 32'h7);
    cand_n <= 8'hFF;
    rd(8'h00, 32'h0001_C000, 2'h0);
    wr(8'h00, 32'h0001_C000, 2'h0);
    wr(8'h08, 32'h0000_00D1, 2'h0);
    cand_n <= 8'hFC;
    repeat (3) @(posedge clk);
    check("pins enabled", {29'h0, pout_n}, 32'h6);
    cand_n <= 8'hFF;
    rd(8'h00, 32'h0000_4000, 2'h0);
    wr(8'h00, 32'h0000_4000, 2'h0);
  endtask : t_pulses

  task automatic t_harm();
    strobe(1);
    rd(8'h00, 32'h0008_0000, 2'h0);
    wr(8'h00, 32'h0008_0000, 2'h0);
    wr(8'h0C, 32'h0000_0002, 2'h0);
    strobe(2);
    strobe(1);
    rd(8'h00, 32'h0, 2'h0);
    repeat (SETTLE) @(posedge clk);
    strobe(1);
    rd(8'h00, 32'h0008_0000, 2'h0);
    wr(8'h00, 32'h0008_0000, 2'h0);
    wr(8'h0C, 32'h0, 2'h0);
  endtask : t_harm

  task automatic t_irq();
    wr(8'h10, 32'h0002_0000, 2'h0);
    strobe(0);
    repeat (3) @(posedge clk);
    check("irq raised", {31'h0, irq}, 32'h1);
    wr(8'h10, 32'h0, 2'h0);
    repeat (3) @(posedge clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    rd(8'h00, 32'h0002_0000, 2'h0);
    wr(8'h10, 32'h0002_0000, 2'h0);
    wr(8'h00, 32'h0002_0000, 2'h0);
    repeat (3) @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
  endtask : t_irq

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_regs();
    t_signs();
    t_pulses();
    t_harm();
    t_irq();
    summarize();
  end
endmodule : testbench
`default_nettype wire
